// ===== verilog/ebs_pkg.sv
// shared constants and types of the expansion bus access sequencer
package ebs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_TARGETS = 4;
  localparam int TGT_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // phase length fields: a field value n gives n+1 cycles
  localparam int ALEN_W = 2;
  localparam int SLEN_W = 2;
  localparam int PLEN_W = 4;
  localparam int HLEN_W = 2;
  localparam int RLEN_W = 4;
  localparam int CNT_W = 4;
  localparam int RUN_W = 5;

  // address held on the shared lines after the latch strobe falls
  localparam int LATCH_TO_ADDRESS_HOLD_CYC = 1;
  localparam logic [CNT_W-1:0] LATCH_HOLD_LOAD = CNT_W'(LATCH_TO_ADDRESS_HOLD_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [RUN_W-1:0] RUN_RST = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [NUM_TARGETS-1:0] CS_IDLE_N = 4'hf;
  localparam logic [TGT_W-1:0] TGT_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // access sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AHOLD,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_RECOV
  } ebs_state_t;

endpackage : ebs_pkg

// ===== verilog/ebs_phase_cnt.sv
// down counter that times one phase of an expansion bus access
`timescale 1ns/1ns
module ebs_phase_cnt
  import ebs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // load and status
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic done
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  assign done = (cnt_q == CNT_RST);
  assign cnt_d = load ? load_val : (done ? cnt_q : cnt_q - 4'h1);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : ebs_phase_cnt

// ===== verilog/ebs_sequencer.sv
// expansion bus access sequencer: phases, strobes, chip selects and data lines
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
// Function
// - multiplexed: latch strobe high 1 to 4 cycles per address phase length
// - multiplexed: address stays exactly one cycle after latch strobe falls
// - multiplexed: address valid when latch strobe rises
// - multiplexed: chip select asserts exactly one cycle after latch strobe falls
// - simplex: no latch strobe; chip select 1 to 4 cycles after address
// - address phase length sets how long address shows before setup
// - separate strobes: write data valid 1 to 4 cycles before write strobe
// - separate strobes: write strobe low 1 to 16 cycles per strobe length
// - separate strobes: write data kept 1 to 4 cycles after strobe rises
// - hold phase keeps chip select, address and write data
// - strobe length sets strobe active time; data present throughout
// - recovery of 1 to 16 cycles between successive accesses
// - single strobe: write data valid 1 to 4 cycles before data strobe
// - single strobe: data strobe low 1 to 16 cycles per strobe length
// - single strobe: write data kept 1 to 4 cycles after strobe rises
// - all phases counted in whole cycles of the one bus clock
module ebs_sequencer
  import ebs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // access request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [TGT_W-1:0] req_target,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  // access completion
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic busy,
  // per target configuration
  input wire logic [NUM_TARGETS-1:0] cfg_muxed,
  input wire logic [NUM_TARGETS-1:0] cfg_single_strobe,
  input wire logic [NUM_TARGETS*ALEN_W-1:0] cfg_address_phase_len,
  input wire logic [NUM_TARGETS*SLEN_W-1:0] cfg_setup_phase_len,
  input wire logic [NUM_TARGETS*PLEN_W-1:0] cfg_strobe_phase_len,
  input wire logic [NUM_TARGETS*HLEN_W-1:0] cfg_hold_phase_len,
  input wire logic [NUM_TARGETS*RLEN_W-1:0] cfg_recovery_phase_len,
  // expansion bus pins
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic [DATA_W-1:0] bus_data_in,
  output logic [NUM_TARGETS-1:0] chip_select_n,
  output logic address_latch_strobe,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic single_data_strobe_n,
  output logic read_not_write
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  ebs_state_t state_q;
  ebs_state_t state_d;
  logic accept;
  logic phase_done;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_load_val;
  logic [DATA_W-1:0] din_s1_q;
  logic [DATA_W-1:0] din_s2_q;
  logic [TGT_W-1:0] cur_tgt_q;
  logic cur_write_q;
  logic cur_muxed_q;
  logic cur_single_q;
  logic [ALEN_W-1:0] cur_alen_q;
  logic [SLEN_W-1:0] cur_slen_q;
  logic [PLEN_W-1:0] cur_plen_q;
  logic [HLEN_W-1:0] cur_hlen_q;
  logic [RLEN_W-1:0] cur_rlen_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [TGT_W-1:0] sel_tgt;
  logic sel_write;
  logic sel_muxed;
  logic sel_single;
  logic [ALEN_W-1:0] sel_alen;
  logic [SLEN_W-1:0] sel_slen;
  logic [PLEN_W-1:0] sel_plen;
  logic [HLEN_W-1:0] sel_hlen;
  logic [RLEN_W-1:0] sel_rlen;
  logic [ADDR_W-1:0] sel_addr;
  logic [DATA_W-1:0] sel_wdata;
  logic in_access_d;
  logic in_addr_d;
  logic in_cs_d;
  logic in_data_d;
  logic [NUM_TARGETS-1:0] cs_n_d;
  logic [NUM_TARGETS-1:0] cs_n_q;
  logic ale_q;
  logic wr_n_q;
  logic rd_n_q;
  logic ds_n_q;
  logic rnw_q;
  logic [ADDR_W-1:0] bus_addr_q;
  logic [DATA_W-1:0] bus_dout_q;
  logic [DATA_W-1:0] bus_dout_d;
  logic bus_oe_q;
  logic bus_oe_d;
  logic rsp_valid_q;
  logic [DATA_W-1:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser for the read data pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      din_s1_q <= DATA_RST;
      din_s2_q <= DATA_RST;
    end else begin
      din_s1_q <= bus_data_in;
      din_s2_q <= din_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request acceptance and per target selection
  assign req_ready = (state_q == ST_IDLE);
  assign accept = req_valid && req_ready;
  assign busy = !req_ready;
  assign sel_tgt = accept ? req_target : cur_tgt_q;
  assign sel_write = accept ? req_write : cur_write_q;
  assign sel_muxed = accept ? cfg_muxed[req_target] : cur_muxed_q;
  assign sel_single = accept ? cfg_single_strobe[req_target] : cur_single_q;
  assign sel_alen = accept ? cfg_address_phase_len[req_target*ALEN_W +: ALEN_W] : cur_alen_q;
  assign sel_slen = accept ? cfg_setup_phase_len[req_target*SLEN_W +: SLEN_W] : cur_slen_q;
  assign sel_plen = accept ? cfg_strobe_phase_len[req_target*PLEN_W +: PLEN_W] : cur_plen_q;
  assign sel_hlen = accept ? cfg_hold_phase_len[req_target*HLEN_W +: HLEN_W] : cur_hlen_q;
  assign sel_rlen = accept ? cfg_recovery_phase_len[req_target*RLEN_W +: RLEN_W] : cur_rlen_q;
  assign sel_addr = accept ? req_addr : addr_q;
  assign sel_wdata = accept ? req_wdata : wdata_q;

  // configuration is snapshotted so a change mid access has no effect
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_tgt_q <= TGT_RST;
      cur_write_q <= 1'b0;
      cur_muxed_q <= 1'b0;
      cur_single_q <= 1'b0;
      cur_alen_q <= '0;
      cur_slen_q <= '0;
      cur_plen_q <= '0;
      cur_hlen_q <= '0;
      cur_rlen_q <= '0;
      addr_q <= ADDR_RST;
      wdata_q <= DATA_RST;
    end else begin
      cur_tgt_q <= sel_tgt;
      cur_write_q <= sel_write;
      cur_muxed_q <= sel_muxed;
      cur_single_q <= sel_single;
      cur_alen_q <= sel_alen;
      cur_slen_q <= sel_slen;
      cur_plen_q <= sel_plen;
      cur_hlen_q <= sel_hlen;
      cur_rlen_q <= sel_rlen;
      addr_q <= sel_addr;
      wdata_q <= sel_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencing, one bus clock per count
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          state_d = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (phase_done) begin
          state_d = cur_muxed_q ? ST_AHOLD : ST_SETUP;
        end
      end
      ST_AHOLD: begin
        if (phase_done) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (phase_done) begin
          state_d = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (phase_done) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (phase_done) begin
          state_d = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (phase_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // each phase counter load comes from its programmed length, except the latch hold, which loads LATCH_HOLD_LOAD
  assign cnt_load = (state_d != state_q);
  always_comb begin
    cnt_load_val = CNT_RST;
    case (state_d)
      ST_ADDR: cnt_load_val = CNT_W'(sel_alen);
      ST_AHOLD: cnt_load_val = LATCH_HOLD_LOAD;
      ST_SETUP: cnt_load_val = CNT_W'(sel_slen);
      ST_STROBE: cnt_load_val = sel_plen;
      ST_HOLD: cnt_load_val = CNT_W'(sel_hlen);
      ST_RECOV: cnt_load_val = sel_rlen;
      default: cnt_load_val = CNT_RST;
    endcase
  end

  ebs_phase_cnt u_cnt (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(cnt_load),
    .load_val(cnt_load_val),
    .done(phase_done)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin decode from the next state, registered so pins align with state_q
  assign in_access_d = (state_d != ST_IDLE) && (state_d != ST_RECOV);
  assign in_addr_d = (state_d == ST_ADDR) || (state_d == ST_AHOLD);
  assign in_cs_d = (state_d == ST_SETUP) || (state_d == ST_STROBE) || (state_d == ST_HOLD);
  assign in_data_d = in_cs_d && sel_write;
  assign bus_oe_d = in_data_d || (in_addr_d && sel_muxed);
  assign bus_dout_d = in_data_d ? sel_wdata : ((in_addr_d && sel_muxed) ? sel_addr[DATA_W-1:0] : DATA_RST);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TARGETS; gi++) begin : g_cs
      assign cs_n_d[gi] = !(in_cs_d && (sel_tgt == TGT_W'(gi)));
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_n_q <= CS_IDLE_N;
      ale_q <= 1'b0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      ds_n_q <= 1'b1;
      rnw_q <= 1'b1;
      bus_addr_q <= ADDR_RST;
      bus_dout_q <= DATA_RST;
      bus_oe_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_d;
      ale_q <= (state_d == ST_ADDR) && sel_muxed;
      wr_n_q <= !((state_d == ST_STROBE) && !sel_single && sel_write);
      rd_n_q <= !((state_d == ST_STROBE) && !sel_single && !sel_write);
      ds_n_q <= !((state_d == ST_STROBE) && sel_single);
      rnw_q <= in_access_d ? !sel_write : 1'b1;
      bus_addr_q <= in_access_d ? sel_addr : ADDR_RST;
      bus_dout_q <= bus_dout_d;
      bus_oe_q <= bus_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read capture on the last strobe cycle, completion pulse after hold
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= DATA_RST;
      rsp_valid_q <= 1'b0;
    end else begin
      if ((state_q == ST_STROBE) && phase_done && !cur_write_q) begin
        rdata_q <= din_s2_q;
      end
      rsp_valid_q <= (state_q == ST_HOLD) && phase_done;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
  assign chip_select_n = cs_n_q;
  assign address_latch_strobe = ale_q;
  assign write_strobe_n = wr_n_q;
  assign read_strobe_n = rd_n_q;
  assign single_data_strobe_n = ds_n_q;
  assign read_not_write = rnw_q;
  assign bus_addr = bus_addr_q;
  assign bus_data_out = bus_dout_q;
  assign bus_data_oe = bus_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [RUN_W-1:0] run_q;
  logic [RUN_W-1:0] ale_run_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_q <= RUN_RST;
      ale_run_q <= RUN_RST;
    end else begin
      run_q <= (state_d == state_q) ? run_q + 5'h01 : RUN_RST;
      ale_run_q <= ale_q ? ale_run_q + 5'h01 : RUN_RST;
    end
  end

  property p_ale_len;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(ale_q) |-> (ale_run_q == RUN_W'(cur_alen_q) + 5'h01);
  endproperty
  a_ale_len: assert property (p_ale_len) else $error("latch strobe length wrong");

  property p_addr_hold;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(ale_q) |-> (bus_oe_q && bus_dout_q == addr_q[DATA_W-1:0]) ##1 (state_q == ST_SETUP);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address hold after latch not one cycle");

  property p_addr_at_ale;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(ale_q) |-> (bus_oe_q && bus_dout_q == addr_q[DATA_W-1:0]);
  endproperty
  a_addr_at_ale: assert property (p_addr_at_ale) else $error("address not valid at latch rise");

  property p_cs_after_ale;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(ale_q) |-> (&cs_n_q) ##1 !(&cs_n_q);
  endproperty
  a_cs_after_ale: assert property (p_cs_after_ale) else $error("chip select timing after latch wrong");

  property p_simplex;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_ADDR && !cur_muxed_q && phase_done) |-> !ale_q ##1 !(&cs_n_q);
  endproperty
  a_simplex: assert property (p_simplex) else $error("simplex latch or chip select wrong");

  property p_wr_setup;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(write_strobe_n) |-> ($past(state_q) == ST_SETUP && $past(run_q) == RUN_W'(cur_slen_q) && $past(bus_oe_q));
  endproperty
  a_wr_setup: assert property (p_wr_setup) else $error("write data setup length wrong");

  property p_wr_pulse;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(write_strobe_n) |-> ($past(run_q) == RUN_W'(cur_plen_q) && bus_oe_q && bus_dout_q == wdata_q);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe width wrong");

  property p_ds_setup;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(single_data_strobe_n) |-> ($past(run_q) == RUN_W'(cur_slen_q) && (bus_oe_q == cur_write_q));
  endproperty
  a_ds_setup: assert property (p_ds_setup) else $error("data strobe setup length wrong");

  property p_ds_pulse;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(single_data_strobe_n) |-> ($past(run_q) == RUN_W'(cur_plen_q) && state_q == ST_HOLD);
  endproperty
  a_ds_pulse: assert property (p_ds_pulse) else $error("data strobe width wrong");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_HOLD && state_d == ST_RECOV) |->
        (run_q == RUN_W'(cur_hlen_q) && !(&cs_n_q) && bus_addr_q == addr_q && (bus_oe_q == cur_write_q));
  endproperty
  a_hold: assert property (p_hold) else $error("hold phase length or held signals wrong");

  property p_recov;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_RECOV && state_d == ST_IDLE) |-> (run_q == RUN_W'(cur_rlen_q) && (&cs_n_q));
  endproperty
  a_recov: assert property (p_recov) else $error("recovery length wrong");

  property p_order;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_STROBE && state_d != ST_STROBE) |-> (state_d == ST_HOLD) ##1 (state_d inside {ST_HOLD, ST_RECOV});
  endproperty
  a_order: assert property (p_order) else $error("phase order broken");

  c_mux_write: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(write_strobe_n) && cur_muxed_q);
  c_simplex_read: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(read_strobe_n) && !cur_muxed_q);
  c_single_strobe: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(single_data_strobe_n));
  c_back_to_back: cover property (@(posedge core_clk) disable iff (!rst_n) rsp_valid_q ##[1:20] accept);

endmodule : ebs_sequencer

// ===== sim/ebs_ext_dev.sv
// far-side device model that answers reads on the expansion bus
`timescale 1ns/1ns
module ebs_ext_dev
  import ebs_pkg::*;
(
  // clock
  input wire logic core_clk,
  // bus pins seen by the device
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic read_strobe_n,
  input wire logic single_data_strobe_n,
  input wire logic read_not_write,
  output logic [DATA_W-1:0] bus_data_in
);
  logic [DATA_W-1:0] filler = 16'h0000;
  wire logic rd_on = !read_strobe_n || (!single_data_strobe_n && read_not_write);
  wire logic [DATA_W-1:0] rd_word = {bus_addr[7:0], ~bus_addr[15:8]};
  // released lines change every cycle so stale data never passes for a good read
  always @(negedge core_clk) filler <= ~filler;
  // word stays stable for the whole strobe, through its rising edge
  assign bus_data_in = rd_on ? rd_word : filler;
endmodule : ebs_ext_dev

// ===== sim/test_ebs_sequencer.sv
// self-checking bench for the expansion bus access sequencer
`timescale 1ns/1ns
module test_ebs_sequencer;
  import ebs_pkg::*;
  typedef struct {logic [TGT_W-1:0] t; logic w, m, s; logic [ADDR_W-1:0] ad; logic [DATA_W-1:0] d;
    int a, su, p, h, r;} ebs_note_t;
  ////////////////////////////////////////////////////////////////////////////
  logic core_clk = 0;
  logic rst_n = 0;
  logic req_valid = 0, req_write = 0, req_ready, rsp_valid, busy, bus_data_oe;
  logic address_latch_strobe, write_strobe_n, read_strobe_n, single_data_strobe_n, read_not_write;
  logic [TGT_W-1:0] req_target = '0;
  logic [ADDR_W-1:0] req_addr = '0, bus_addr;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, bus_data_out, bus_data_in;
  logic [3:0] cfg_muxed = '0, cfg_single_strobe = '0, chip_select_n;
  logic [7:0] cfg_address_phase_len = '0, cfg_setup_phase_len = '0, cfg_hold_phase_len = '0;
  logic [15:0] cfg_strobe_phase_len = '0, cfg_recovery_phase_len = '0;
  ebs_note_t q[$];
  ebs_note_t cur;
  int miscompares = 0, checked = 0;
  int pre, su, p, h, na, bad, rec, exp_r;
  bit seen, was_ale, in_rec, strb;
  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  ebs_sequencer i_ebs_sequencer (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_target(req_target), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
    .cfg_muxed(cfg_muxed), .cfg_single_strobe(cfg_single_strobe),
    .cfg_address_phase_len(cfg_address_phase_len), .cfg_setup_phase_len(cfg_setup_phase_len),
    .cfg_strobe_phase_len(cfg_strobe_phase_len), .cfg_hold_phase_len(cfg_hold_phase_len),
    .cfg_recovery_phase_len(cfg_recovery_phase_len), .bus_addr(bus_addr), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in), .chip_select_n(chip_select_n),
    .address_latch_strobe(address_latch_strobe), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .single_data_strobe_n(single_data_strobe_n),
    .read_not_write(read_not_write));
  ebs_ext_dev i_ebs_ext_dev (.core_clk(core_clk), .bus_addr(bus_addr), .read_strobe_n(read_strobe_n),
    .single_data_strobe_n(single_data_strobe_n), .read_not_write(read_not_write),
    .bus_data_in(bus_data_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_n(input string nm, input int e, input int g);
    checked++;
    if (e !== g) begin
      miscompares++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_n

  task automatic cmp_d(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checked++;
    if (e !== g) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_d

  task automatic close_out;
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  // other targets get random settings so a wrong slot selection shows
  task automatic access(input logic [TGT_W-1:0] tg, input logic w, m, s, input int a, sl, pl, hl, rl);
    ebs_note_t n;
    logic [3:0] mx, sx;
    logic [7:0] av, sv, hv;
    logic [15:0] pv, rv;
    int k;
    {mx, sx, av, sv, hv} = 32'($urandom);
    pv = 16'($urandom);
    rv = 16'($urandom);
    mx[tg] = m;
    sx[tg] = s;
    av[tg*2+:2] = 2'(a);
    sv[tg*2+:2] = 2'(sl);
    hv[tg*2+:2] = 2'(hl);
    pv[tg*4+:4] = 4'(pl);
    rv[tg*4+:4] = 4'(rl);
    n = '{tg, w, m, s, 24'($urandom), 16'($urandom), a + 1, sl + 1, pl + 1, hl + 1, rl + 1};
    @(posedge core_clk);
    cfg_muxed <= mx;
    cfg_single_strobe <= sx;
    cfg_address_phase_len <= av;
    cfg_setup_phase_len <= sv;
    cfg_hold_phase_len <= hv;
    cfg_strobe_phase_len <= pv;
    cfg_recovery_phase_len <= rv;
    req_valid <= 1'b1;
    req_write <= w;
    req_target <= tg;
    req_addr <= n.ad;
    req_wdata <= n.d;
    k = 0;
    do @(negedge core_clk); while (req_ready !== 1'b1 && ++k < 100);
    @(posedge core_clk);
    q.push_back(n);
    req_valid <= 1'b0;
    cfg_strobe_phase_len <= ~pv;
  endtask : access
  ////////////////////////////////////////////////////////////////////////////
  // monitor: counts phase lengths on the pins, compares on each completion
  always @(negedge core_clk) begin
    if (in_rec && busy === 1'b1) rec++;
    else if (in_rec) begin
      cmp_n("recovery", exp_r, rec);
      in_rec = 0;
    end
    if (q.size() > 0) begin
      cur = q[0];
      strb = cur.s ? !single_data_strobe_n : (cur.w ? !write_strobe_n : !read_strobe_n);
      if (rsp_valid === 1'b1) begin
        void'(q.pop_front());
        cmp_n("latch_len", cur.m ? cur.a : 0, na);
        cmp_n("pre_select", cur.a + cur.m, pre);
        cmp_n("setup_len", cur.su, su);
        cmp_n("strobe_len", cur.p, p);
        cmp_n("hold_len", cur.h, h);
        cmp_n("pin_faults", 0, bad);
        if (!cur.w) cmp_d("rdata", {cur.ad[7:0], ~cur.ad[15:8]}, rsp_rdata);
        {pre, su, p, h, na, bad, seen, was_ale} = '0;
        in_rec = 1;
        rec = 1;
        exp_r = cur.r;
      end else begin
        if (address_latch_strobe === 1'b1) begin
          na++;
          if (!cur.m || bus_data_out !== cur.ad[15:0] || bus_addr !== cur.ad) bad++;
        end else if (was_ale && (bus_data_out !== cur.ad[15:0] || chip_select_n !== 4'hf)) bad++;
        was_ale = address_latch_strobe === 1'b1;
        if (read_not_write !== !cur.w) bad++;
        if (cur.s ? (write_strobe_n !== 1'b1 || read_strobe_n !== 1'b1)
            : (single_data_strobe_n !== 1'b1 || (cur.w ? read_strobe_n : write_strobe_n) !== 1'b1)) bad++;
        if (chip_select_n === 4'hf) pre++;
        else begin
          if (chip_select_n !== ~(4'h1 << cur.t) || bus_addr !== cur.ad) bad++;
          if (cur.w ? (bus_data_oe !== 1'b1 || bus_data_out !== cur.d) : bus_data_oe !== 1'b0) bad++;
          if (strb) begin
            p++;
            seen = 1;
          end else if (!seen) su++;
          else h++;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    void'($urandom(48334));
    repeat (3) @(posedge core_clk);
    cmp_d("idle_pins", 16'h0bcf, {4'h0, req_ready, address_latch_strobe, write_strobe_n, read_strobe_n,
      single_data_strobe_n, read_not_write, bus_data_oe, rsp_valid, chip_select_n});
    rst_n <= 1'b1;
    // every style and direction at both ends of the length ranges, except read strobe length, which is 2 at the low end
    for (int i = 0; i < 16; i++) begin
      if (i[3]) access(2'(i), i[0], i[1], i[2], 3, 3, 15, 3, 15);
      else access(2'(i), i[0], i[1], i[2], 0, 0, i[0] ? 0 : 2, 0, 0);
    end
    for (int i = 0; i < 24; i++) begin
      access(2'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), $urandom % 4, $urandom % 4,
        2 + $urandom % 14, $urandom % 4, $urandom % 16);
    end
    k = 0;
    while ((q.size() > 0 || in_rec) && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 200) miscompares++;
    close_out();
  end

  initial begin
    #(20000 * 50);
    miscompares++;
    close_out();
  end
endmodule : test_ebs_sequencer
